// file: core/break_unit_pkg.sv
// Purpose: constants for the bus-cycle break matcher
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses of aligned words
package break_unit_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_ADDR_HI    = 8'h00;
  localparam logic [7:0]  OFF_ADDR_LO    = 8'h04;
  localparam logic [7:0]  OFF_MASK_HI    = 8'h08;
  localparam logic [7:0]  OFF_MASK_LO    = 8'h0C;
  localparam logic [7:0]  OFF_CYCLE_SEL  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h18;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_HALF       = 16'h0000;
  localparam logic [7:0]  RST_CYCLE_SEL  = 8'h00;
  localparam int          POS_REQ        = 6;
  localparam int          POS_KIND       = 4;
  localparam int          POS_DIR        = 2;
  localparam int          POS_SIZE       = 0;
  // ----------------------------------------------------------------
  // bus cycle encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  SIZE_ANY       = 2'h0;
  localparam logic [1:0]  SIZE_BYTE      = 2'h1;
  localparam logic [1:0]  SIZE_WORD      = 2'h2;
  localparam logic [1:0]  SIZE_LONG      = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [3:0]  BREAK_LEVEL    = 4'hF;
  // pc save selection
  typedef enum logic [1:0] {PC_MATCH, PC_NEXT, PC_AFTER_LAST} pc_sel_t;
endpackage

// file: core/break_unit.sv
// Purpose: bus-cycle break matcher with AXI4-Lite register slave
// Assumes: bus cycle inputs are valid for one cycle each, synchronous to I_CLK
// Notes:   I_HW_STANDBY acts as an extra synchronous clear of all settings
//
// Operation
// - cycle select clears on reset and hardware standby, kept in software standby
// - upper eight bits of cycle select read zero; writers write zero
// - requester field 00 none, 01 processor, 10 dma/transfer, 11 both
// - access kind field 00 none, 01 fetch, 10 data, 11 both
// - direction field 00 none, 01 read, 10 write, 11 both
// - size field 00 any size, 01 byte, 10 word, 11 longword
// - every instruction fetch counts as a word access
// - compared size is the access's own size, never bus width
// - any of requester, kind, direction at 00 blocks every break
// - full match of all conditions raises a break request
// - request carries level 15, taken when mask level is 14 or lower
// - both instructions of a 32-bit fetch match independently
// - fetch break taken before execution, saved pc is the fetch address
// - delay slot or inhibited fetch: execute first, save next address
// - data match breaks imprecisely, saves address after last executed
// - mask bit 1 drops that address bit from the comparison
// - break address held as two halves, cleared on reset and standby
`timescale 1ns/1ps
module break_unit
  import break_unit_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_HW_STANDBY,
  // axi4-lite write
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // watched bus cycle
  input  wire logic        I_CYC_VALID,
  input  wire logic [31:0] I_CYC_ADDR,
  input  wire logic        I_CYC_DMA,
  input  wire logic        I_CYC_FETCH,
  input  wire logic        I_CYC_WRITE,
  input  wire logic [1:0]  I_CYC_SIZE,
  input  wire logic        I_CYC_DUAL,
  input  wire logic        I_CYC_NO_ACCEPT,
  // processor side
  input  wire logic [3:0]  I_MASK_LEVEL,
  input  wire logic        I_BREAK_ACK,
  // break outputs
  output logic             O_BREAK_REQ,
  output logic [3:0]       O_BREAK_LEVEL,
  output logic [31:0]      O_SAVE_ADDR,
  output logic [1:0]       O_PC_SEL,
  output logic             O_BREAK_SECOND,
  output logic             O_IRQ
);

  // ----------------------------------------------------------------
  // matching functions
  // ----------------------------------------------------------------
  function automatic logic sel_ok(input logic [1:0] sel, input logic is_hi);
    sel_ok = is_hi ? sel[1] : sel[0];
  endfunction

  function automatic logic addr_ok(input logic [31:0] a, input logic [31:0] ref_a,
                                   input logic [31:0] msk);
    addr_ok = ((a ^ ref_a) & ~msk) == 32'h0000_0000;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] addr_hi_r;
  logic [15:0] addr_lo_r;
  logic [15:0] mask_hi_r;
  logic [15:0] mask_lo_r;
  logic [7:0]  cyc_sel_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic        wr_fire;
  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic [1:0]  eff_size;
  logic        attr_ok;
  logic        hit_first;
  logic        hit_second;
  logic        hit;

  assign brk_addr = {addr_hi_r, addr_lo_r};
  assign brk_mask = {mask_hi_r, mask_lo_r};
  assign wr_fire  = aw_have_r && w_have_r && !O_BVALID;

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
    end else begin
      O_AWREADY <= !aw_have_r && !(I_AWVALID && O_AWREADY);
      O_WREADY  <= !w_have_r && !(I_WVALID && O_WREADY);
      if (I_AWVALID && O_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB;
      end
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= (aw_addr_r <= OFF_IRQ_MASK && aw_addr_r[1:0] == 2'h0)
                    ? RESP_OKAY : RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  // software standby is not an input: only power-on and hardware standby clear
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      addr_hi_r <= RST_HALF;
      addr_lo_r <= RST_HALF;
      mask_hi_r <= RST_HALF;
      mask_lo_r <= RST_HALF;
      cyc_sel_r <= RST_CYCLE_SEL;
      irq_mask_r <= 2'h0;
    end else if (I_HW_STANDBY) begin
      addr_hi_r <= RST_HALF;
      addr_lo_r <= RST_HALF;
      mask_hi_r <= RST_HALF;
      mask_lo_r <= RST_HALF;
      cyc_sel_r <= RST_CYCLE_SEL;
      irq_mask_r <= 2'h0;
    end else if (wr_fire) begin
      unique case (aw_addr_r)
        OFF_ADDR_HI:    addr_hi_r <= merge16(addr_hi_r, w_data_r, w_strb_r);
        OFF_ADDR_LO:    addr_lo_r <= merge16(addr_lo_r, w_data_r, w_strb_r);
        OFF_MASK_HI:    mask_hi_r <= merge16(mask_hi_r, w_data_r, w_strb_r);
        OFF_MASK_LO:    mask_lo_r <= merge16(mask_lo_r, w_data_r, w_strb_r);
        // upper byte is not stored, so it cannot be set
        OFF_CYCLE_SEL:  if (w_strb_r[0]) cyc_sel_r <= w_data_r[7:0];
        OFF_IRQ_MASK:   if (w_strb_r[0]) irq_mask_r <= w_data_r[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= RESP_OKAY;
    end else begin
      O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
      if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RRESP  <= RESP_OKAY;
        unique case (I_ARADDR)
          OFF_ADDR_HI:    O_RDATA <= {16'h0000, addr_hi_r};
          OFF_ADDR_LO:    O_RDATA <= {16'h0000, addr_lo_r};
          OFF_MASK_HI:    O_RDATA <= {16'h0000, mask_hi_r};
          OFF_MASK_LO:    O_RDATA <= {16'h0000, mask_lo_r};
          OFF_CYCLE_SEL:  O_RDATA <= {24'h000000, cyc_sel_r};
          OFF_IRQ_STATUS: O_RDATA <= {30'h0, irq_stat_r};
          OFF_IRQ_MASK:   O_RDATA <= {30'h0, irq_mask_r};
          default: begin
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= RESP_SLVERR;
          end
        endcase
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // cycle comparison
  // ----------------------------------------------------------------
  // fetch size is forced to word; bus width is never an input here
  assign eff_size = I_CYC_FETCH ? SIZE_WORD : I_CYC_SIZE;
  assign attr_ok  = sel_ok(cyc_sel_r[POS_REQ+:2], I_CYC_DMA)
                 && sel_ok(cyc_sel_r[POS_KIND+:2], !I_CYC_FETCH)
                 && sel_ok(cyc_sel_r[POS_DIR+:2], I_CYC_WRITE)
                 && (cyc_sel_r[POS_SIZE+:2] == SIZE_ANY
                     || cyc_sel_r[POS_SIZE+:2] == eff_size);
  assign hit_first  = addr_ok(I_CYC_ADDR, brk_addr, brk_mask);
  // second instruction sits at fetch address plus two
  assign hit_second = I_CYC_FETCH && I_CYC_DUAL
                   && addr_ok(I_CYC_ADDR + 32'h0000_0002, brk_addr, brk_mask);
  assign hit = I_CYC_VALID && attr_ok && (hit_first || hit_second);

  // ----------------------------------------------------------------
  // break request toward the interrupt controller
  // ----------------------------------------------------------------
  // a pending break holds its capture; a later hit is dropped until taken
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_BREAK_REQ    <= 1'b0;
      O_SAVE_ADDR    <= 32'h0000_0000;
      O_PC_SEL       <= PC_MATCH;
      O_BREAK_SECOND <= 1'b0;
      O_BREAK_LEVEL  <= BREAK_LEVEL;
    end else if (O_BREAK_REQ) begin
      // pending while the mask level stays at fifteen
      if (I_BREAK_ACK && I_MASK_LEVEL < BREAK_LEVEL) O_BREAK_REQ <= 1'b0;
    end else if (hit) begin
      O_BREAK_REQ    <= 1'b1;
      O_BREAK_SECOND <= !hit_first;
      O_SAVE_ADDR    <= hit_first ? I_CYC_ADDR : I_CYC_ADDR + 32'h0000_0002;
      if (!I_CYC_FETCH) O_PC_SEL <= PC_AFTER_LAST;
      else if (I_CYC_NO_ACCEPT) O_PC_SEL <= PC_NEXT;
      else O_PC_SEL <= PC_MATCH;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: bit0 hit, bit1 hit lost while pending
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_stat_r <= 2'h0;
      O_IRQ      <= 1'b0;
    end else begin
      // set wins over a write-one clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~((wr_fire && aw_addr_r == OFF_IRQ_STATUS && w_strb_r[0])
                                    ? w_data_r[1:0] : 2'h0))
                    | {hit && O_BREAK_REQ, hit};
      O_IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_zero_blocks;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      (cyc_sel_r[7:6] == 2'h0 || cyc_sel_r[5:4] == 2'h0 || cyc_sel_r[3:2] == 2'h0)
      && !O_BREAK_REQ |=> !O_BREAK_REQ;
  endproperty
  a_zero_blocks: assert property (p_zero_blocks) else $error("break with a zero field");

  property p_hit_raises;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      hit && !O_BREAK_REQ |=> O_BREAK_REQ;
  endproperty
  a_hit_raises: assert property (p_hit_raises) else $error("match raised no break");

  property p_pending_held;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      O_BREAK_REQ && I_MASK_LEVEL == BREAK_LEVEL |=> O_BREAK_REQ;
  endproperty
  a_pending_held: assert property (p_pending_held) else $error("break dropped at mask 15");

  property p_fetch_pc;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      hit && !O_BREAK_REQ && I_CYC_FETCH && hit_first
      |=> O_SAVE_ADDR == $past(I_CYC_ADDR);
  endproperty
  a_fetch_pc: assert property (p_fetch_pc) else $error("saved pc not fetch address");

  property p_data_pc;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      hit && !O_BREAK_REQ && !I_CYC_FETCH |=> O_PC_SEL == PC_AFTER_LAST;
  endproperty
  a_data_pc: assert property (p_data_pc) else $error("data break pc selection wrong");

  property p_fetch_no_byte;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      I_CYC_VALID && I_CYC_FETCH && cyc_sel_r[1:0] == SIZE_BYTE && !O_BREAK_REQ
      |=> !O_BREAK_REQ;
  endproperty
  a_fetch_no_byte: assert property (p_fetch_no_byte) else $error("fetch matched byte");

  property p_cyc_sel_upper;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      O_RVALID && $past(I_ARADDR) == OFF_CYCLE_SEL && $rose(O_RVALID)
      |-> O_RDATA[31:8] == 24'h000000;
  endproperty
  a_cyc_sel_upper: assert property (p_cyc_sel_upper) else $error("reserved bits not zero");

  property p_standby_clear;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      I_HW_STANDBY |=> cyc_sel_r == RST_CYCLE_SEL && brk_addr == 32'h0000_0000;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear");

  property p_second_hit;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      hit && !O_BREAK_REQ && !hit_first |=> O_BREAK_SECOND && O_BREAK_REQ;
  endproperty
  a_second_hit: assert property (p_second_hit) else $error("second instruction missed");

  property p_noaccept_pc;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      hit && !O_BREAK_REQ && I_CYC_FETCH && I_CYC_NO_ACCEPT |=> O_PC_SEL == PC_NEXT;
  endproperty
  a_noaccept_pc: assert property (p_noaccept_pc) else $error("delay slot pc wrong");

endmodule

// file: dv/break_host_model.sv
// Purpose: interrupt controller and core side that takes break requests
// Assumes: one clock, registered acknowledge
// Notes:   slow adds a fixed stall before each acknowledge
`timescale 1ns/1ps
module break_host_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // request side
  input  wire logic       i_req,
  input  wire logic [3:0] i_mask_level,
  input  wire logic       i_slow,
  // answer
  output logic            o_ack
);
  logic [2:0] wait_r;
  // a request at mask level 15 stays pending, never acked
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack  <= 1'b0;
      wait_r <= 3'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_req && !o_ack && i_mask_level < 4'hF) begin
        if (wait_r == (i_slow ? 3'h5 : 3'h0)) begin
          o_ack  <= 1'b1;
          wait_r <= 3'h0;
        end else begin
          wait_r <= wait_r + 3'h1;
        end
      end
    end
  end
endmodule

// file: dv/tb.sv
// Purpose: self-checking bench for the bus-cycle break matcher
// Assumes: AXI4-Lite master tasks, fixed random seed
// Notes:   expected hits are worked out by hit() from the field codes
`timescale 1ns/1ps
module tb
  import break_unit_pkg::*;
;
  logic clk = 0, arst_n = 0, stby = 0, slow = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, cyc_addr = 0;
  logic [3:0] wstrb = 0, lvl = 0;
  logic cyc_valid = 0, cyc_dma = 0, cyc_fetch = 0, cyc_write = 0, cyc_dual = 0, cyc_noacc = 0;
  logic [1:0] cyc_size = 0, bresp, rresp, pcsel;
  logic awready, wready, bvalid, arready, rvalid, brk_req, second, irq, ack;
  logic [31:0] rdata, save;
  logic [3:0] brk_lvl;
  int err_total = 0, checked = 0, seed = 67282;
  logic [31:0] d, ba, bm, a;
  logic [7:0] sel;
  logic [1:0] r, sz;
  logic f;

  break_unit uut (.I_CLK(clk), .I_ARST_N(arst_n), .I_HW_STANDBY(stby),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_CYC_VALID(cyc_valid), .I_CYC_ADDR(cyc_addr),
    .I_CYC_DMA(cyc_dma), .I_CYC_FETCH(cyc_fetch), .I_CYC_WRITE(cyc_write),
    .I_CYC_SIZE(cyc_size), .I_CYC_DUAL(cyc_dual), .I_CYC_NO_ACCEPT(cyc_noacc),
    .I_MASK_LEVEL(lvl), .I_BREAK_ACK(ack), .O_BREAK_REQ(brk_req),
    .O_BREAK_LEVEL(brk_lvl), .O_SAVE_ADDR(save), .O_PC_SEL(pcsel),
    .O_BREAK_SECOND(second), .O_IRQ(irq));
  break_host_model host (.i_clk(clk), .i_arst_n(arst_n), .i_req(brk_req),
    .i_mask_level(lvl), .i_slow(slow), .o_ack(ack));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awaddr  <= ad;
    awvalid <= 1'b1;
    wdata   <= dt;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // fetches count as word size whatever the size lines say
  function automatic logic hit(logic [31:0] ad, b, m, logic [7:0] s, logic dm, fe, wr,
                               logic [1:0] z);
    logic [1:0] e;
    e = fe ? SIZE_WORD : z;
    return (((ad ^ b) & ~m) == 32'h0) && s[POS_REQ + dm] && s[POS_KIND + !fe] &&
           s[POS_DIR + wr] && (s[1:0] == SIZE_ANY || s[1:0] == e);
  endfunction

  task automatic trial(input logic [31:0] b, m, input logic [7:0] s, input logic [31:0] ad,
                       input logic dm, fe, wr, input logic [1:0] z, input logic du, na);
    logic h1, h2;
    logic [1:0] rs;
    logic [31:0] dt;
    axw(OFF_ADDR_HI, {16'h0000, b[31:16]}, rs);
    axw(OFF_ADDR_LO, {16'h0000, b[15:0]}, rs);
    axw(OFF_MASK_HI, {16'h0000, m[31:16]}, rs);
    axw(OFF_MASK_LO, {16'h0000, m[15:0]}, rs);
    axw(OFF_CYCLE_SEL, {24'h000000, s}, rs);
    chk(32'(rs), 32'(RESP_OKAY));
    axr(OFF_CYCLE_SEL, dt, rs);
    chk(dt, {24'h000000, s});
    h1 = hit(ad, b, m, s, dm, fe, wr, z);
    h2 = fe && du && hit(ad + 32'h2, b, m, s, dm, fe, wr, z);
    @(posedge clk);
    cyc_addr  <= ad;
    cyc_dma   <= dm;
    cyc_fetch <= fe;
    cyc_write <= wr;
    cyc_size  <= z;
    cyc_dual  <= du;
    cyc_noacc <= na;
    cyc_valid <= 1'b1;
    @(posedge clk);
    cyc_valid <= 1'b0;
    #1;
    chk(32'(brk_req), 32'(h1 | h2));
    if (h1 | h2) begin
      chk(save, h1 ? ad : ad + 32'h2);
      chk(32'(second), 32'(!h1));
      chk(32'(pcsel), 32'(!fe ? 2'h2 : (na ? 2'h1 : 2'h0)));
      chk(32'(brk_lvl), 32'(BREAK_LEVEL));
    end
    while (brk_req === 1'b1 && lvl != 4'hF) @(posedge clk);
  endtask

  initial begin
    #300us;
    err_total++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int o = 0; o <= 24; o += 4) begin
      axr(o[7:0], d, r);
      chk(d, 32'h0);
    end
    axr(8'h1C, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axw(8'h1C, 32'h0000_0001, r);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("test reset_values finished");
    trial(32'h0000_0404, 32'h0, 8'h54, 32'h0000_0404, 1'b0, 1'b1, 1'b0, SIZE_WORD, 1'b0, 1'b0);
    trial(32'h0015_389C, 32'h0, 8'h58, 32'h0015_389C, 1'b0, 1'b1, 1'b0, SIZE_WORD, 1'b0, 1'b0);
    trial(32'h0012_3456, 32'h0, 8'h6A, 32'h0012_3456, 1'b0, 1'b0, 1'b1, SIZE_WORD, 1'b0, 1'b0);
    trial(32'h0076_BCDC, 32'h0, 8'hA7, 32'h0076_BCDC, 1'b1, 1'b0, 1'b0, SIZE_LONG, 1'b0, 1'b0);
    trial(32'h0000_1002, 32'h0, 8'h5C, 32'h0000_1000, 1'b0, 1'b1, 1'b0, SIZE_LONG, 1'b1, 1'b1);
    trial(32'h0000_2000, 32'h0, 8'h54, 32'h0000_2000, 1'b0, 1'b1, 1'b0, SIZE_BYTE, 1'b0, 1'b1);
    $display("test corner_cases finished");
    for (int i = 0; i < 300; i++) begin
      ba = $random(seed);
      bm = $random(seed) & $random(seed);
      a = ba ^ ($random(seed) & bm);
      if (i % 5 == 0) a = $random(seed);
      if (i % 7 == 0) a = a - 32'h2;
      sel = 8'($random(seed));
      f = 1'($random(seed));
      if (f) sel[0] = 1'b0;
      sz = 2'($random(seed));
      if (sz == SIZE_ANY) sz = SIZE_LONG;
      slow <= 1'($random(seed));
      trial(ba, bm, sel, a, 1'($random(seed)), f, 1'($random(seed)), sz, 1'($random(seed)),
            1'($random(seed)));
    end
    $display("test random_cycles finished");
    slow <= 1'b0;
    axw(OFF_IRQ_STATUS, 32'h3, r);
    axw(OFF_IRQ_MASK, 32'h1, r);
    lvl <= 4'hF;
    trial(32'h0000_0400, 32'h0, 8'h7C, 32'h0000_0400, 1'b0, 1'b0, 1'b1, SIZE_BYTE, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    #1;
    chk(32'(brk_req), 32'h1);
    chk(32'(irq), 32'h1);
    trial(32'h0000_0400, 32'h0, 8'h7C, 32'h0000_0400, 1'b0, 1'b0, 1'b1, SIZE_BYTE, 1'b0, 1'b0);
    lvl <= 4'hE;
    for (int n = 0; n < 20 && brk_req === 1'b1; n++) @(posedge clk);
    #1;
    chk(32'(brk_req), 32'h0);
    axr(OFF_IRQ_STATUS, d, r);
    chk(d, 32'h3);
    axw(OFF_IRQ_STATUS, 32'h3, r);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0);
    axw(OFF_IRQ_MASK, 32'h0, r);
    trial(32'h0000_0400, 32'h0, 8'h7C, 32'h0000_0400, 1'b0, 1'b0, 1'b1, SIZE_BYTE, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0);
    $display("test pending_and_irq finished");
    axw(OFF_ADDR_HI, 32'h0000_1234, r);
    axw(OFF_MASK_LO, 32'h0000_00F0, r);
    axw(OFF_CYCLE_SEL, 32'h0000_0055, r);
    @(posedge clk);
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    for (int o = 0; o <= 16; o += 4) begin
      axr(o[7:0], d, r);
      chk(d, 32'h0);
    end
    $display("test hw_standby finished");
    stop_test;
  end
endmodule
